// [core/can_rx_consts.svh]
// Constants for the receiver interrupt enable and status-change block.
//
// Contract
// - Enable bits sit at reset value while init request and acknowledge both set.
// - Enable register writes land only when init request and acknowledge clear.
// - Both sensitivity fields keep their values through initialization mode.
// - Wake enable bit 7 gates the wake flag onto the wake request.
// - Status change enable bit 6 gates the status change flag onto error request.
// - Receiver sensitivity 5:4 picks which receiver state changes raise the flag.
// - Transmitter sensitivity 3:2 picks which transmitter changes raise the flag.
// - Receiver state bits track real state, updated only with no change pending.
// - Transmitter state bits track real state, updated only with no change pending.
// - Overrun enable bit 1 gates the overrun flag onto the error request.
// - Receive full enable bit 0 gates receive full flag onto receive request.
// - Transmitter leaving bus-off to OK forces receiver state to OK together.
// - Receiver code: 00 up to 96, 01 to 127, 10 above, 11 bus-off.
`ifndef CAN_RX_CONSTS_SVH
`define CAN_RX_CONSTS_SVH

// ==========================================================================
// Register byte offsets.
`define OFS_RX_INTERRUPT_ENABLE 8'h00
`define OFS_RX_FLAG_REGISTER 8'h04
`define OFS_CONTROL 8'h08

// ==========================================================================
// Field positions of the enable, flag and control registers.
`define BIT_WAKE 7
`define BIT_STATUS_CHANGE 6
`define BIT_OVERRUN 1
`define BIT_RX_FULL 0
`define EVENT_MASK 8'hC3
`define SENS_MASK 8'h3C
`define BIT_INIT_REQUEST 0
`define BIT_INIT_ACKNOWLEDGE 1
`define BIT_WAKE_FUNCTION 2

// ==========================================================================
// Reset values.
`define RX_INTERRUPT_ENABLE_RESET 8'h00
`define RX_FLAG_RESET 8'h00

// ==========================================================================
// Error count limits (96, 127, 255) and state and sensitivity codes.
`define WARN_LIMIT 9'h060
`define PASSIVE_LIMIT 9'h07F
`define BUSOFF_LIMIT 9'h0FF
`define ST_OK 2'h0
`define ST_WARN 2'h1
`define ST_PASSIVE 2'h2
`define ST_BUSOFF 2'h3
`define SENS_NONE 2'h0
`define SENS_BUSOFF 2'h1
`define SENS_PASSIVE 2'h2
`define SENS_ALL 2'h3

`endif

// [core/can_rx_pkg.sv]
// Types shared by the receiver interrupt enable block.
package can_rx_pkg;

  // Bus slave states, one-hot.
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_READ = 2'b10
  } bus_state_t;

  // Two-bit error state code.
  typedef logic [1:0] err_state_t;

endpackage

// [core/can_state_track.sv]
// Error state tracking and status-change detection.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_consts.svh"

module can_state_track (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // Error counters from the protocol engine.
  input wire logic [8:0] rx_err_count,
  input wire logic [8:0] tx_err_count,
  // Sensitivity and the pending status change flag.
  input wire logic [1:0] rx_sens,
  input wire logic [1:0] tx_sens,
  input wire logic flag_pending,
  // Reported state bits and the change event.
  output logic [1:0] rx_state_bits,
  output logic [1:0] tx_state_bits,
  output logic status_change
);

  // ========================================================================
  // Decoders.
  function automatic can_rx_pkg::err_state_t level_of(input logic [8:0] cnt);
    if (cnt > `BUSOFF_LIMIT) begin
      return `ST_BUSOFF;
    end else if (cnt > `PASSIVE_LIMIT) begin
      return `ST_PASSIVE;
    end else if (cnt > `WARN_LIMIT) begin
      return `ST_WARN;
    end
    return `ST_OK;
  endfunction

  // A change counts when it crosses the boundary chosen by the sensitivity.
  function automatic logic sens_hit(input logic [1:0] sens, input logic [1:0] a,
                                    input logic [1:0] b);
    logic boff;
    boff = (a == `ST_BUSOFF) != (b == `ST_BUSOFF);
    case (sens)
      `SENS_BUSOFF: return boff;
      `SENS_PASSIVE: return boff || (a[1] != b[1]);
      `SENS_ALL: return a != b;
      default: return 1'b0;
    endcase
  endfunction

  // ========================================================================
  // Actual states.
  can_rx_pkg::err_state_t tx_now;
  can_rx_pkg::err_state_t rx_cnt_level;
  can_rx_pkg::err_state_t rx_now;
  logic tx_recover;
  logic update;
  assign tx_now = level_of(tx_err_count);
  assign rx_cnt_level = level_of(rx_err_count);
  // The receive counter has no bus-off of its own, so it tops out at passive.
  assign tx_recover = (tx_state_bits == `ST_BUSOFF) && (tx_now == `ST_OK);
  assign rx_now = (tx_now == `ST_BUSOFF) ? `ST_BUSOFF :
                  tx_recover ? `ST_OK :
                  (rx_cnt_level == `ST_BUSOFF) ? `ST_PASSIVE : rx_cnt_level;

  // Reported bits freeze while a status change is pending.
  assign update = !flag_pending && ((rx_now != rx_state_bits) || (tx_now != tx_state_bits));
  assign status_change = update && (sens_hit(rx_sens, rx_state_bits, rx_now) ||
                                    sens_hit(tx_sens, tx_state_bits, tx_now));

  // State bit registers.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state_bits <= `ST_OK;
      tx_state_bits <= `ST_OK;
    end else if (update) begin
      rx_state_bits <= rx_now;
      tx_state_bits <= tx_now;
    end
  end

  // ========================================================================
  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_bits_frozen: assert property (flag_pending |=> $stable(rx_state_bits) && $stable(tx_state_bits))
    else $error("State bits moved while a change was pending.");
  a_busoff_rx: assert property (!flag_pending && tx_err_count > `BUSOFF_LIMIT
    |=> rx_state_bits == `ST_BUSOFF && tx_state_bits == `ST_BUSOFF)
    else $error("Bus-off not shown in both state fields.");
  a_rx_warn_code: assert property (!flag_pending && tx_err_count <= `WARN_LIMIT &&
    tx_state_bits == `ST_OK && rx_err_count > `WARN_LIMIT && rx_err_count <= `PASSIVE_LIMIT
    |=> rx_state_bits == `ST_WARN)
    else $error("Receiver warning code wrong.");
  a_sens_none: assert property (rx_sens == `SENS_NONE && tx_sens == `SENS_NONE |-> !status_change)
    else $error("Change raised with both sensitivities off.");
  c_recover: cover property (tx_recover && update);

endmodule

`default_nettype wire

// [core/can_rx_irq_enable_gating.sv]
// Receiver interrupt enable register, event flags and request gating.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_consts.svh"

module can_rx_irq_enable_gating (
  // Clock and reset.
  input wire logic hclk,
  input wire logic hresetn,
  // AHB-Lite slave.
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // Protocol engine events and counters.
  input wire logic wake_activity,
  input wire logic overrun_event,
  input wire logic rx_full_event,
  input wire logic [8:0] rx_err_count,
  input wire logic [8:0] tx_err_count,
  // Control seen by the protocol engine.
  output logic init_acknowledge,
  output logic wake_function_en,
  // Interrupt requests.
  output logic wake_irq,
  output logic err_irq,
  output logic rx_irq,
  output logic irq
);

  // ========================================================================
  // Storage.
  can_rx_pkg::bus_state_t bus_state_q;
  can_rx_pkg::bus_state_t bus_state_d;
  logic [7:0] addr_q;
  logic wr_pend_q;
  logic [7:0] rx_interrupt_enable_q;
  logic [7:0] rx_interrupt_enable_d;
  logic [7:0] flag_q;
  logic [7:0] flag_d;
  logic init_request_q;
  logic init_ack_q;
  logic wake_fn_q;
  logic [31:0] hrdata_q;
  logic hreadyout_q;
  logic wake_irq_q;
  logic err_irq_q;
  logic rx_irq_q;
  logic irq_q;

  // ========================================================================
  // Bus decode.
  wire take = hsel && hready && htrans[1];
  wire take_read = take && !hwrite;
  wire in_read = (bus_state_q == can_rx_pkg::BUS_READ);
  wire hit_rie = (addr_q == `OFS_RX_INTERRUPT_ENABLE);
  wire hit_flag = (addr_q == `OFS_RX_FLAG_REGISTER);
  wire hit_ctl = (addr_q == `OFS_CONTROL);
  wire wr_rie = wr_pend_q && hit_rie;
  wire wr_ctl = wr_pend_q && hit_ctl;
  wire rd_clear = in_read && hit_flag;

  // Bus state steps: a read waits one cycle so a write just before it lands first.
  always_comb begin
    case (bus_state_q)
      can_rx_pkg::BUS_IDLE: bus_state_d = take_read ? can_rx_pkg::BUS_READ :
                                                      can_rx_pkg::BUS_IDLE;
      can_rx_pkg::BUS_READ: bus_state_d = can_rx_pkg::BUS_IDLE;
      default: bus_state_d = can_rx_pkg::BUS_IDLE;
    endcase
  end

  // Address phase capture.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_state_q <= can_rx_pkg::BUS_IDLE;
      addr_q <= 8'h00;
      wr_pend_q <= 1'b0;
    end else begin
      bus_state_q <= bus_state_d;
      wr_pend_q <= take && hwrite;
      if (take) begin
        addr_q <= haddr[7:0];
      end
    end
  end

  // ========================================================================
  // Initialization mode. Acknowledge follows request one cycle later.
  wire in_init = init_request_q && init_ack_q;
  wire write_ok = !init_request_q && !init_ack_q;

  // Control register, writable at any time.
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      init_request_q <= 1'b0;
      init_ack_q <= 1'b0;
      wake_fn_q <= 1'b0;
    end else begin
      init_ack_q <= init_request_q;
      if (wr_ctl) begin
        init_request_q <= hwdata[`BIT_INIT_REQUEST];
        wake_fn_q <= hwdata[`BIT_WAKE_FUNCTION];
      end
    end
  end

  // ========================================================================
  // Enable register. Writes during the request handshake are dropped silently,
  // since the write would race the hold that follows.
  wire [7:0] init_hold = (rx_interrupt_enable_q & `SENS_MASK) |
                         (`RX_INTERRUPT_ENABLE_RESET & ~`SENS_MASK);
  assign rx_interrupt_enable_d = (wr_rie && write_ok) ? hwdata[7:0] :
                                 in_init ? init_hold :
                                 rx_interrupt_enable_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_interrupt_enable_q <= `RX_INTERRUPT_ENABLE_RESET;
    end else begin
      rx_interrupt_enable_q <= rx_interrupt_enable_d;
    end
  end

  wire [1:0] rx_sens = rx_interrupt_enable_q[5:4];
  wire [1:0] tx_sens = rx_interrupt_enable_q[3:2];

  // ========================================================================
  // State tracking.
  logic [1:0] rx_state_bits;
  logic [1:0] tx_state_bits;
  logic status_change;

  can_state_track u_track (
    .hclk(hclk),
    .hresetn(hresetn),
    .rx_err_count(rx_err_count),
    .tx_err_count(tx_err_count),
    .rx_sens(rx_sens),
    .tx_sens(tx_sens),
    .flag_pending(flag_q[`BIT_STATUS_CHANGE]),
    .rx_state_bits(rx_state_bits),
    .tx_state_bits(tx_state_bits),
    .status_change(status_change)
  );

  // ========================================================================
  // Event flags: sticky, cleared by a read, and a new event beats the clear.
  wire wake_set = wake_activity && wake_fn_q;
  wire [7:0] flag_set = {wake_set, status_change, 4'h0, overrun_event, rx_full_event};
  wire [7:0] flag_keep = rd_clear ? 8'h00 : (flag_q & `EVENT_MASK);
  assign flag_d = flag_set | flag_keep;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= `RX_FLAG_RESET;
    end else begin
      flag_q <= flag_d;
    end
  end

  // ========================================================================
  // Request gating.
  wire [7:0] pend = flag_q & rx_interrupt_enable_q & `EVENT_MASK;
  wire wake_req = pend[`BIT_WAKE];
  wire err_req = pend[`BIT_STATUS_CHANGE] || pend[`BIT_OVERRUN];
  wire rx_req = pend[`BIT_RX_FULL];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wake_irq_q <= 1'b0;
      err_irq_q <= 1'b0;
      rx_irq_q <= 1'b0;
      irq_q <= 1'b0;
    end else begin
      wake_irq_q <= wake_req;
      err_irq_q <= err_req;
      rx_irq_q <= rx_req;
      irq_q <= |pend;
    end
  end

  // ========================================================================
  // Read data. Upper bits read as zero, unmapped offsets read as zero.
  wire [7:0] flag_view = {flag_q[7:6], rx_state_bits, tx_state_bits, flag_q[1:0]};
  wire [7:0] ctl_view = {5'h00, wake_fn_q, init_ack_q, init_request_q};
  wire [7:0] rd_byte = hit_rie ? rx_interrupt_enable_q :
                       hit_flag ? flag_view :
                       hit_ctl ? ctl_view : 8'h00;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
      hreadyout_q <= 1'b1;
    end else begin
      hreadyout_q <= !take_read;
      if (in_read) begin
        hrdata_q <= {24'h00_0000, rd_byte};
      end
    end
  end

  // ========================================================================
  // Outputs.
  assign hrdata = hrdata_q;
  assign hreadyout = hreadyout_q;
  assign hresp = 1'b0;
  assign init_acknowledge = init_ack_q;
  assign wake_function_en = wake_fn_q;
  assign wake_irq = wake_irq_q;
  assign err_irq = err_irq_q;
  assign rx_irq = rx_irq_q;
  assign irq = irq_q;

  // ========================================================================
  // Checks.
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  a_init_hold: assert property (in_init |=> (rx_interrupt_enable_q & `EVENT_MASK) == 8'h00)
    else $error("Enable bits not held during init.");
  a_write_blocked: assert property (wr_rie && (init_request_q != init_ack_q)
    |=> $stable(rx_interrupt_enable_q))
    else $error("Enable write landed during init handshake.");
  a_sens_kept: assert property (in_init |=> rx_interrupt_enable_q[5:2] ==
    $past(rx_interrupt_enable_q[5:2]))
    else $error("Sensitivity lost in init.");
  a_wake_gate: assert property (wake_activity && wake_fn_q && rx_interrupt_enable_q[7]
    ##1 rx_interrupt_enable_q[7] |=> wake_irq)
    else $error("Wake request missing.");
  a_status_gate: assert property (status_change && rx_interrupt_enable_q[6]
    ##1 rx_interrupt_enable_q[6] |=> err_irq && irq)
    else $error("Status change request missing.");
  a_overrun_gate: assert property (overrun_event && rx_interrupt_enable_q[1]
    ##1 rx_interrupt_enable_q[1] |=> err_irq)
    else $error("Overrun request missing.");
  a_rx_gate: assert property (rx_full_event && rx_interrupt_enable_q[0]
    ##1 rx_interrupt_enable_q[0] |=> rx_irq)
    else $error("Receive request missing.");
  a_masked_quiet: assert property ((rx_interrupt_enable_q & `EVENT_MASK) == 8'h00
    |=> !wake_irq && !err_irq && !rx_irq && !irq)
    else $error("Request raised with all enables off.");
  a_read_clears: assert property (rd_clear && !(|flag_set)
    |=> (flag_q & `EVENT_MASK) == 8'h00)
    else $error("Flag read did not clear flags.");
  c_wake_irq: cover property (wake_set ##2 wake_irq);
  c_status_change: cover property (status_change ##1 flag_q[`BIT_STATUS_CHANGE]);
  c_set_beats_clear: cover property (rd_clear && rx_full_event);

endmodule

`default_nettype wire

// [test/ahb_master_model.sv]
// Register bus master model standing in for the processor side.
`timescale 1ns/10ps
`default_nettype none

module ahb_master_model (
  // Clock and handshake from the slave.
  input wire logic hclk,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  // Address and data phase signals.
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // ==========================================================================
  // Idle bus from time zero, so no transfer is seen before reset ends.
  initial begin
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'b010;
    hwdata = 32'h0000_0000;
  end

  // One single word transfer; waits as long as the slave holds ready low.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd);
    @(posedge hclk);
    hsel <= 1'b1;
    haddr <= {24'h00_0000, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    // Stale write data is inverted so the slave cannot lean on a held value.
    hwdata <= ~wd;
  endtask
endmodule

`default_nettype wire

// [test/can_rx_irq_enable_gating_tb_top.sv]
// Self-checking bench for the receiver interrupt enable block.
`timescale 1ns/10ps
`default_nettype none
`include "can_rx_consts.svh"

module can_rx_irq_enable_gating_tb_top;
  logic hclk;
  logic hresetn;
  logic hsel, hwrite, hreadyout;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic wake_activity, overrun_event, rx_full_event;
  logic [8:0] rx_err_count, tx_err_count;
  logic init_acknowledge, wake_irq, err_irq, rx_irq, irq;
  logic hresp, wake_function_en;
  int n_mismatch = 0;
  int n_compared = 0;
  int cycles = 0;

  // ==========================================================================
  // Design and bus master.
  can_rx_irq_enable_gating i_can_rx_irq_enable_gating (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .wake_activity(wake_activity), .overrun_event(overrun_event),
    .rx_full_event(rx_full_event), .rx_err_count(rx_err_count),
    .tx_err_count(tx_err_count), .init_acknowledge(init_acknowledge),
    .wake_function_en(wake_function_en), .wake_irq(wake_irq), .err_irq(err_irq),
    .rx_irq(rx_irq),
    .irq(irq));
  ahb_master_model i_ahb_master_model (
    .hclk(hclk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  // Clock, and a cycle ceiling well above the several hundred cycles the run needs.
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cycles++;
    if (cycles == 20000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  // ==========================================================================
  // Shared tasks and the reference model.
  task automatic wrap_up();
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_ahb_master_model.xfer(1'b1, a, d, rd);
  endtask
  task automatic rdv(input logic [7:0] a);
    i_ahb_master_model.xfer(1'b0, a, 32'h0000_0000, rd);
  endtask
  // Events are {wake, overrun, receive full}; returns once requests have settled.
  task automatic pulse(input logic [2:0] ev);
    @(posedge hclk);
    wake_activity <= ev[2];
    overrun_event <= ev[1];
    rx_full_event <= ev[0];
    @(posedge hclk);
    wake_activity <= 1'b0;
    overrun_event <= 1'b0;
    rx_full_event <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  task automatic chk_irq(input logic [7:0] e, input logic [7:0] f);
    logic w, x, r;
    w = e[7] & f[7];
    x = (e[6] & f[6]) | (e[1] & f[1]);
    r = e[0] & f[0];
    chk("wake_irq", 32'(wake_irq), 32'(w));
    chk("err_irq", 32'(err_irq), 32'(x));
    chk("rx_irq", 32'(rx_irq), 32'(r));
    chk("irq", 32'(irq), 32'(w | x | r));
  endtask
  task automatic wait_ack(input logic v);
    repeat (8) begin
      rdv(`OFS_CONTROL);
      if (rd[1] === v) break;
    end
    chk("init_acknowledge", 32'(init_acknowledge), 32'(v));
  endtask
  // A random count inside a state band: ok, warning, passive, bus-off.
  function automatic int band(input int b);
    case (b)
      0: return $urandom % 97;
      1: return 97 + $urandom % 31;
      2: return 128 + $urandom % 128;
      default: return 256 + $urandom % 256;
    endcase
  endfunction
  function automatic int sens_hit(input int s, input int a, input int b);
    case (s)
      1: return int'((a == 3) != (b == 3));
      2: return int'(((a >= 2) != (b >= 2)) || ((a == 3) != (b == 3)));
      3: return int'(a != b);
      default: return 0;
    endcase
  endfunction

  // ==========================================================================
  // Main sequence.
  initial begin
    int s;
    int sd;
    int hit;
    int pr;
    int path[$];
    logic [7:0] e;
    logic [7:0] f;
    logic [2:0] ev;
    hresetn = 1'b0;
    wake_activity = 1'b0;
    overrun_event = 1'b0;
    rx_full_event = 1'b0;
    rx_err_count = 9'h000;
    tx_err_count = 9'h000;
    void'($urandom(32'hd653587a));
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    rdv(`OFS_RX_INTERRUPT_ENABLE);
    chk("enable_reset", rd, 32'(`RX_INTERRUPT_ENABLE_RESET));
    chk("hresp", 32'(hresp), 32'h0000_0000);
    chk_irq(8'h00, 8'h00);
    // Initialization mode clears the enables but keeps both sensitivity fields.
    wr(`OFS_RX_INTERRUPT_ENABLE, 32'h0000_00FF);
    rdv(`OFS_RX_INTERRUPT_ENABLE);
    chk("enable_rw", rd, 32'h0000_00FF);
    pulse(3'b001);
    chk_irq(8'hFF, 8'h01);
    wr(`OFS_CONTROL, 32'h0000_0001);
    wait_ack(1'b1);
    rdv(`OFS_RX_INTERRUPT_ENABLE);
    chk("enable_init", rd, 32'h0000_003C);
    chk_irq(8'h3C, 8'h01);
    wr(`OFS_RX_INTERRUPT_ENABLE, 32'h0000_0001);
    rdv(`OFS_RX_INTERRUPT_ENABLE);
    chk("enable_locked", rd, 32'h0000_003C);
    wr(`OFS_CONTROL, 32'h0000_0004);
    wait_ack(1'b0);
    chk("wake_function_en", 32'(wake_function_en), 32'h0000_0001);
    rdv(`OFS_RX_FLAG_REGISTER);
    chk("flag_rx_full", rd, 32'h0000_0001);
    // Random enables against random event mixes.
    for (int i = 0; i < 12; i++) begin
      e = 8'($urandom) & `EVENT_MASK;
      ev = 3'($urandom);
      f = {ev[2], 5'b00000, ev[1], ev[0]};
      wr(`OFS_RX_INTERRUPT_ENABLE, 32'(e));
      pulse(ev);
      chk_irq(e, f);
      rdv(`OFS_RX_FLAG_REGISTER);
      chk("flag_events", rd, 32'(f));
      repeat (2) @(posedge hclk);
      chk_irq(e, 8'h00);
    end
    // Each sensitivity code walked through state crossings on each side.
    for (s = 0; s < 4; s++) begin
      for (sd = 0; sd < 2; sd++) begin
        e = (sd == 0) ? {2'b01, 2'(s), 4'b0000} : {4'b0100, 2'(s), 2'b00};
        wr(`OFS_RX_INTERRUPT_ENABLE, 32'(e));
        if (sd == 0) path = '{1, 2, 0, 2, 1, 0};
        else path = '{2, 3, 0, 1, 3, 0};
        pr = 0;
        foreach (path[k]) begin
          if (sd == 0) rx_err_count <= 9'(band(path[k]));
          else tx_err_count <= 9'(band(path[k]));
          hit = sens_hit(s, pr, path[k]);
          repeat (6) @(posedge hclk);
          chk("err_irq_sens", 32'(err_irq), 32'(hit));
          rdv(`OFS_RX_FLAG_REGISTER);
          f = {1'b0, 1'(hit), 2'(sd == 0 ? path[k] : (path[k] == 3 ? 3 : 0)),
               2'(sd == 0 ? 0 : path[k]), 2'b00};
          chk("flag_state", rd, 32'(f));
          pr = path[k];
        end
      end
    end
    // A pending change freezes the reported state until the flag is read.
    wr(`OFS_RX_INTERRUPT_ENABLE, 32'h0000_0070);
    rx_err_count <= 9'(band(1));
    repeat (6) @(posedge hclk);
    rx_err_count <= 9'(band(2));
    repeat (6) @(posedge hclk);
    rdv(`OFS_RX_FLAG_REGISTER);
    chk("state_frozen", rd & 32'h0000_0030, 32'h0000_0010);
    repeat (6) @(posedge hclk);
    rdv(`OFS_RX_FLAG_REGISTER);
    chk("state_tracks", rd & 32'h0000_0030, 32'h0000_0020);
    wrap_up();
  end
endmodule

`default_nettype wire
